// file: rtl/mlb_dev.sv
// concentrator end of the master link: registers, tester, counters, loopback
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module mlb_dev #(
   parameter int MBIT = mlb_pkg::MBIT_BITS
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   mlb_if.dev               link,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic [7:0]  tx_msg,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [7:0]       fwd_msg,
   output logic             fwd_valid
);
   typedef struct packed {
      logic [31:0]     ctrl;
      logic [31:0]     rdata;
      logic            c1;
      logic            c2;
      logic            cd;
      logic            d1;
      logic            d2;
      logic            win;
      logic [1:0]      idx;
      logic            bv;
      logic            rb;
      logic            rx_busy;
      logic [3:0]      rx_cnt;
      logic [7:0]      rx_sh;
      logic [7:0]      fmsg;
      logic            fvld;
      logic [9:0]      tx_sh;
      logic [3:0]      tx_cnt;
      logic            miso;
      logic            rdy;
      mlb_pkg::mlb_lb_e lb;
      logic [3:0]      gap;
      logic [30:0]     tx_lfsr;
      logic [30:0]     rx_lfsr;
      logic [30:0]     hist;
      logic [4:0]      fill;
      logic            lock;
      logic            inj;
      logic [23:0]     rx_msg;
      logic [23:0]     rx_err;
      logic [23:0]     tx_cntr;
      logic [19:0]     rx_mb;
      logic [19:0]     tx_mb;
      logic [23:0]     cap;
   } mlb_dev_s;

   mlb_dev_s r, next_r;
   logic [1:0] pat;
   logic       ena, b, e, wr_ctrl, load;
   logic [9:0] frm;

   always_comb begin
      next_r = r;
      pat = r.ctrl[mlb_pkg::PAT_LSB +: 2];
      ena = r.ctrl[mlb_pkg::ENA_BIT];
      b = 1'b0;
      e = 1'b0;
      load = 1'b0;
      frm = '0;
      wr_ctrl = reg_wr && reg_addr == mlb_pkg::CTRL_ADDR;
      next_r.fvld = 1'b0;
      next_r.bv = 1'b0;
      // ----------------------------------------------------------------
      // pin synchronisers and sampling window
      // ----------------------------------------------------------------
      next_r.c1 = link.link_clk;
      next_r.c2 = r.c1;
      next_r.cd = r.c2;
      next_r.d1 = link.link_mosi;
      next_r.d2 = r.d1;
      if (r.win) begin
         next_r.idx = r.idx + 2'h1;
         next_r.win = r.idx != 2'h3;
         if (r.idx == r.ctrl[mlb_pkg::PHASE_LSB +: 2]) begin
            next_r.rb = r.d2 ^ r.ctrl[mlb_pkg::RXINV_BIT];
            next_r.bv = 1'b1;
         end
      end
      if (r.c2 && !r.cd) begin
         next_r.win = 1'b1;
         next_r.idx = 2'h0;
      end
      // ----------------------------------------------------------------
      // receive path
      // ----------------------------------------------------------------
      if (r.bv && ena) begin
         // tester owns the inbound stream; framing is bypassed
         b = r.rb;
         next_r.hist = {r.hist[29:0], b};
         next_r.rx_mb = r.rx_mb + 20'h1;
         if (r.rx_mb == 20'(MBIT - 1)) begin
            next_r.rx_mb = 20'h0;
            next_r.rx_msg = r.rx_msg + 24'h1;
         end
         if (r.fill != mlb_pkg::mlb_prbs_len(pat)) begin
            next_r.fill = r.fill + 5'h1;
         end else if (!r.lock && r.ctrl[mlb_pkg::RXEN_BIT]) begin
            // last n bits of a maximal sequence occur once: they are the seed
            next_r.rx_lfsr = {r.hist[29:0], b};
            next_r.lock = 1'b1;
         end
         if (r.lock) begin
            // generator keeps step while compare is off, so a resume stays aligned
            e = mlb_pkg::mlb_prbs_fb(r.rx_lfsr, pat);
            next_r.rx_lfsr = {r.rx_lfsr[29:0], e};
            if (r.ctrl[mlb_pkg::RXEN_BIT] && e != b) begin
               next_r.rx_err = r.rx_err + 24'h1;
            end
         end
      end else if (r.bv) begin
         b = r.rb;
         if (!r.rx_busy) begin
            next_r.rx_busy = b;
            next_r.rx_cnt = 4'h0;
         end else if (r.rx_cnt == 4'h8) begin
            next_r.rx_busy = 1'b0;
            next_r.rx_msg = r.rx_msg + 24'h1;
            if ((^r.rx_sh) != b) begin
               next_r.rx_err = r.rx_err + 24'h1;
            end else if (r.ctrl[mlb_pkg::LOOP_BIT]) begin
               if (r.rx_sh == mlb_pkg::MSG_START) begin
                  next_r.lb = mlb_pkg::MLB_LB_ACK;
               end else if (r.rx_sh == mlb_pkg::MSG_STOP) begin
                  next_r.lb = mlb_pkg::MLB_LB_SET;
               end
            end else begin
               next_r.fmsg = r.rx_sh;
               next_r.fvld = 1'b1;
            end
         end else begin
            next_r.rx_sh = {r.rx_sh[6:0], b};
            next_r.rx_cnt = r.rx_cnt + 4'h1;
         end
      end
      if (!ena) begin
         next_r.lock = 1'b0;
         next_r.fill = 5'h0;
      end
      // ----------------------------------------------------------------
      // transmit path: one bit per received falling edge
      // ----------------------------------------------------------------
      if (!r.c2 && r.cd) begin
         if (ena && r.ctrl[mlb_pkg::TXEN_BIT]) begin
            e = mlb_pkg::mlb_prbs_fb(r.tx_lfsr, pat);
            next_r.tx_lfsr = {r.tx_lfsr[29:0], e};
            b = e ^ r.inj;
            next_r.inj = 1'b0;
            next_r.tx_mb = r.tx_mb + 20'h1;
            if (r.tx_mb == 20'(MBIT - 1)) begin
               next_r.tx_mb = 20'h0;
               next_r.tx_cntr = r.tx_cntr + 24'h1;
            end
         end else if (r.tx_cnt != 4'h0) begin
            b = r.tx_sh[9];
            next_r.tx_sh = {r.tx_sh[8:0], 1'b0};
            next_r.tx_cnt = r.tx_cnt - 4'h1;
         end else if (r.lb == mlb_pkg::MLB_LB_GAP) begin
            next_r.gap = r.gap - 4'h1;
            if (r.gap == 4'h0) begin
               next_r.lb = mlb_pkg::MLB_LB_CLR;
            end
         end
         next_r.miso = b ^ r.ctrl[mlb_pkg::TXINV_BIT];
      end
      // a load on a bit edge is safe: that edge sends an idle bit
      if (!ena && r.tx_cnt == 4'h0) begin
         case (r.lb)
            mlb_pkg::MLB_LB_ACK: begin
               frm = mlb_pkg::mlb_frame(mlb_pkg::MSG_START_ACK);
               load = 1'b1;
               next_r.lb = mlb_pkg::MLB_LB_IDLE;
            end
            mlb_pkg::MLB_LB_SET: begin
               frm = mlb_pkg::mlb_frame(mlb_pkg::MSG_BUSY_SET);
               load = 1'b1;
               next_r.lb = mlb_pkg::MLB_LB_GAP;
               next_r.gap = 4'(mlb_pkg::LOOP_GAP_BITS - 1);
            end
            mlb_pkg::MLB_LB_CLR: begin
               frm = mlb_pkg::mlb_frame(mlb_pkg::MSG_BUSY_CLR);
               load = 1'b1;
               next_r.lb = mlb_pkg::MLB_LB_IDLE;
            end
            mlb_pkg::MLB_LB_IDLE: begin
               frm = mlb_pkg::mlb_frame(tx_msg);
               load = tx_valid && r.rdy;
            end
            default: begin
               frm = '0;
            end
         endcase
         if (load) begin
            next_r.tx_sh = frm;
            next_r.tx_cnt = 4'hA;
            next_r.tx_cntr = r.tx_cntr + 24'h1;
         end
      end
      next_r.rdy = !ena && !r.ctrl[mlb_pkg::LOOP_BIT] && r.lb == mlb_pkg::MLB_LB_IDLE
                   && next_r.tx_cnt == 4'h0;
      // ----------------------------------------------------------------
      // register port and counter clear/capture
      // ----------------------------------------------------------------
      if (wr_ctrl) begin
         next_r.ctrl = reg_wdata;
         if (reg_wdata[mlb_pkg::INJ_BIT] && !r.ctrl[mlb_pkg::INJ_BIT]) begin
            next_r.inj = 1'b1;
         end
         if (reg_wdata[mlb_pkg::CAP_BIT] && !r.ctrl[mlb_pkg::CAP_BIT]) begin
            // nothing: the snapshot is taken on the falling edge
         end else if (!reg_wdata[mlb_pkg::CAP_BIT] && r.ctrl[mlb_pkg::CAP_BIT]) begin
            case (reg_wdata[mlb_pkg::SEL_LSB +: 2])
               mlb_pkg::SEL_RX_MSG: next_r.cap = r.rx_msg;
               mlb_pkg::SEL_RX_ERR: next_r.cap = r.rx_err;
               mlb_pkg::SEL_TX_MSG: next_r.cap = r.tx_cntr;
               default:             next_r.cap = r.cap;
            endcase
         end
         if (reg_wdata[mlb_pkg::CLR_BIT] && !r.ctrl[mlb_pkg::CLR_BIT]) begin
            case (reg_wdata[mlb_pkg::SEL_LSB +: 2])
               mlb_pkg::SEL_RX_MSG: next_r.rx_msg = 24'h0;
               mlb_pkg::SEL_RX_ERR: next_r.rx_err = 24'h0;
               mlb_pkg::SEL_TX_MSG: next_r.tx_cntr = 24'h0;
               default:             next_r.cap = r.cap;
            endcase
         end
      end
      next_r.rdata = 32'h0;
      if (reg_rd && reg_addr == mlb_pkg::CTRL_ADDR) begin
         next_r.rdata = r.ctrl;
      end else if (reg_rd && reg_addr == mlb_pkg::STAT_ADDR) begin
         next_r.rdata = {r.lock, 7'h0, r.cap};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
         r.ctrl <= mlb_pkg::CTRL_RESET;
         r.tx_lfsr <= mlb_pkg::PRBS_SEED;
      end else begin
         r <= next_r;
      end
   end

   assign link.link_miso = r.miso;
   assign reg_rdata = r.rdata;
   assign tx_ready = r.rdy;
   assign fwd_msg = r.fmsg;
   assign fwd_valid = r.fvld;
endmodule

// file: rtl/mlb_pkg.sv
// shared constants, types and functions of the master link tester ends
package mlb_pkg;
   // ----------------------------------------------------------------
   // register map of the device end
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTRL_ADDR  = 8'h00;
   localparam logic [7:0]  STAT_ADDR  = 8'h04;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam int PAT_LSB  = 0;
   localparam int ENA_BIT  = 2;
   localparam int RXEN_BIT = 3;
   localparam int TXEN_BIT = 4;
   localparam int INJ_BIT  = 5;
   localparam int CLR_BIT  = 6;
   localparam int CAP_BIT  = 7;
   localparam int SEL_LSB  = 8;
   localparam int RXINV_BIT = 10;
   localparam int TXINV_BIT = 11;
   localparam int PHASE_LSB = 12;
   localparam int LOOP_BIT  = 14;
   localparam int LOCK_BIT  = 31;
   localparam logic [1:0] SEL_RX_MSG = 2'h0;
   localparam logic [1:0] SEL_RX_ERR = 2'h1;
   localparam logic [1:0] SEL_TX_MSG = 2'h2;
   // ----------------------------------------------------------------
   // link timing and messages
   // ----------------------------------------------------------------
   localparam int SYS_CLK_NS     = 50;
   localparam int LINK_PERIOD_NS = 400;
   localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * SYS_CLK_NS);
   localparam int MBIT_BITS      = 1000000;
   localparam int LOOP_GAP_BITS  = 4;
   localparam logic [7:0] MSG_START    = 8'h01;
   localparam logic [7:0] MSG_STOP     = 8'h02;
   localparam logic [7:0] MSG_START_ACK = 8'h81;
   localparam logic [7:0] MSG_BUSY_SET = 8'h82;
   localparam logic [7:0] MSG_BUSY_CLR = 8'h83;
   localparam logic [30:0] PRBS_SEED = 31'h7FFFFFFF;

   typedef enum logic [2:0] {MLB_LB_IDLE, MLB_LB_ACK, MLB_LB_SET, MLB_LB_GAP,
                             MLB_LB_CLR} mlb_lb_e;

   // ----------------------------------------------------------------
   // prbs helpers: newest bit sits in bit 0 of the history
   // ----------------------------------------------------------------
   function automatic logic mlb_prbs_fb(input logic [30:0] s, input logic [1:0] pat);
      case (pat)
         2'h0:    mlb_prbs_fb = s[6] ^ s[5];
         2'h1:    mlb_prbs_fb = s[14] ^ s[13];
         2'h2:    mlb_prbs_fb = s[22] ^ s[17];
         default: mlb_prbs_fb = s[30] ^ s[27];
      endcase
   endfunction

   function automatic logic [4:0] mlb_prbs_len(input logic [1:0] pat);
      mlb_prbs_len = 5'(8 * int'(pat) + 7);
   endfunction

   // frame on the wire: start bit 1, eight data bits msb first, even parity
   function automatic logic [9:0] mlb_frame(input logic [7:0] m);
      mlb_frame = {1'b1, m, ^m};
   endfunction
endpackage

// file: rtl/mlb_if.sv
// serial link between the master trigger end and the concentrator end
`timescale 1ns/1ns
interface mlb_if;
   logic link_clk;
   logic link_mosi;
   logic link_miso;
   modport dev (input link_clk, input link_mosi, output link_miso);
   modport mst (output link_clk, output link_mosi, input link_miso);
endinterface

// file: rtl/mlb_mst.sv
// master end: makes the link clock, sends messages or prbs, checks prbs back
`timescale 1ns/1ns
module mlb_mst (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   mlb_if.mst              link,
   input  wire logic [7:0] send_msg,
   input  wire logic       send_valid,
   output logic            send_ready,
   input  wire logic       prbs_en,
   input  wire logic [1:0] prbs_pat,
   input  wire logic       inject,
   output logic [7:0]      rcv_msg,
   output logic            rcv_valid,
   output logic            rcv_perr,
   output logic            bert_locked,
   output logic [15:0]     bert_errs
);
   typedef struct packed {
      logic [2:0]  div;
      logic        lclk;
      logic        mosi;
      logic        s1;
      logic        s2;
      logic [9:0]  tx_sh;
      logic [3:0]  tx_cnt;
      logic        rdy;
      logic [30:0] tx_lfsr;
      logic        inj;
      logic        rx_busy;
      logic [3:0]  rx_cnt;
      logic [7:0]  rx_sh;
      logic [7:0]  msg;
      logic        vld;
      logic        perr;
      logic [30:0] hist;
      logic [30:0] rx_lfsr;
      logic [4:0]  fill;
      logic        lock;
      logic [15:0] errs;
   } mlb_mst_s;

   mlb_mst_s r, next_r;
   logic b, e;

   always_comb begin
      next_r = r;
      b = 1'b0;
      e = 1'b0;
      next_r.vld = 1'b0;
      next_r.s1 = link.link_miso;
      next_r.s2 = r.s1;
      if (send_valid && r.rdy) begin
         next_r.tx_sh = mlb_pkg::mlb_frame(send_msg);
         next_r.tx_cnt = 4'hA;
      end
      if (r.div == 3'(mlb_pkg::LINK_HALF_CYC - 1)) begin
         next_r.div = 3'h0;
         next_r.lclk = ~r.lclk;
         if (r.lclk) begin
            // falling edge: sample the far end and move to the next bit
            b = r.s2;
            if (prbs_en) begin
               next_r.hist = {r.hist[29:0], b};
               if (r.fill != mlb_pkg::mlb_prbs_len(prbs_pat)) begin
                  next_r.fill = r.fill + 5'h1;
               end else if (!r.lock) begin
                  next_r.rx_lfsr = {r.hist[29:0], b};
                  next_r.lock = 1'b1;
               end
               if (r.lock) begin
                  e = mlb_pkg::mlb_prbs_fb(r.rx_lfsr, prbs_pat);
                  next_r.rx_lfsr = {r.rx_lfsr[29:0], e};
                  if (e != b) begin
                     next_r.errs = r.errs + 16'h1;
                  end
               end
               e = mlb_pkg::mlb_prbs_fb(r.tx_lfsr, prbs_pat);
               next_r.tx_lfsr = {r.tx_lfsr[29:0], e};
               next_r.mosi = e ^ r.inj;
               next_r.inj = 1'b0;
            end else begin
               next_r.lock = 1'b0;
               next_r.fill = 5'h0;
               if (!r.rx_busy) begin
                  next_r.rx_busy = b;
                  next_r.rx_cnt = 4'h0;
               end else if (r.rx_cnt == 4'h8) begin
                  next_r.rx_busy = 1'b0;
                  next_r.msg = r.rx_sh;
                  next_r.perr = (^r.rx_sh) != b;
                  next_r.vld = 1'b1;
               end else begin
                  next_r.rx_sh = {r.rx_sh[6:0], b};
                  next_r.rx_cnt = r.rx_cnt + 4'h1;
               end
               next_r.mosi = 1'b0;
               if (r.tx_cnt != 4'h0) begin
                  next_r.mosi = r.tx_sh[9];
                  next_r.tx_sh = {r.tx_sh[8:0], 1'b0};
                  next_r.tx_cnt = r.tx_cnt - 4'h1;
               end
            end
         end
      end else begin
         next_r.div = r.div + 3'h1;
      end
      // a request beside the clear above still wins
      if (inject) begin
         next_r.inj = 1'b1;
      end
      next_r.rdy = !prbs_en && next_r.tx_cnt == 4'h0 && !(send_valid && r.rdy);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
         r.tx_lfsr <= mlb_pkg::PRBS_SEED;
      end else begin
         r <= next_r;
      end
   end

   assign link.link_clk = r.lclk;
   assign link.link_mosi = r.mosi;
   assign send_ready = r.rdy;
   assign rcv_msg = r.msg;
   assign rcv_valid = r.vld;
   assign rcv_perr = r.perr;
   assign bert_locked = r.lock;
   assign bert_errs = r.errs;
endmodule

// file: verif/mlb_monitor.sv
// concurrent checks on the serial link between the master end and the device end
`timescale 1ns/1ns
module mlb_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic link_mosi,
   input wire logic link_miso
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // link clock shape
   // ----------------------------------------------------------------
   chk_clk_high_hold: assert property ($rose(link_clk) |=> link_clk [*3] ##1 !link_clk)
      else $error("link clock high phase is not four cycles");
   chk_clk_low_hold: assert property ($fell(link_clk) |=> !link_clk [*3] ##1 link_clk)
      else $error("link clock low phase is not four cycles");
   chk_clk_alive: assert property (1'b1 |-> ##[1:12] $changed(link_clk))
      else $error("link clock stands still");
   // ----------------------------------------------------------------
   // data lines move only away from their sampling edges
   // ----------------------------------------------------------------
   chk_mosi_low_change: assert property ($changed(link_mosi) |-> !link_clk)
      else $error("inbound line changed while link clock high");
   chk_mosi_hold_high: assert property ($rose(link_clk) |-> $stable(link_mosi) [*4])
      else $error("inbound line not held over the high phase");
   chk_miso_at_sample: assert property ($fell(link_clk) |-> $stable(link_miso))
      else $error("outbound line changed at the master sampling edge");
   chk_miso_change_low: assert property ($changed(link_miso) |-> !link_clk)
      else $error("outbound line changed while link clock high");
   chk_miso_hold_high: assert property ($rose(link_clk) |=> $stable(link_miso) [*3])
      else $error("outbound line not held over the high phase");
endmodule

// file: verif/tb_top.sv
// self-checking bench joining the master end and the device end of the link
`timescale 1ns/1ns
module tb_top;
   localparam int MBIT = 16;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [7:0]  tx_msg = 8'h00;
   logic        tx_valid = 1'b0;
   logic        tx_ready;
   logic [7:0]  fwd_msg;
   logic        fwd_valid;
   logic [7:0]  send_msg = 8'h00;
   logic        send_valid = 1'b0;
   logic        send_ready;
   logic        prbs_en = 1'b0;
   logic        inject = 1'b0;
   logic [1:0]  prbs_pat = 2'h0;
   logic [7:0]  rcv_msg;
   logic        rcv_valid;
   logic        rcv_perr;
   logic        bert_locked;
   logic [15:0] bert_errs;
   logic [15:0] mosi_hist = 16'h0000;
   logic [15:0] miso_hist = 16'h0000;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          n_fwd = 0;

   always #25 sys_clk = ~sys_clk;

   mlb_if link_a ();
   mlb_mst mlb_mst_inst (.sys_clk(sys_clk), .rst(rst), .link(link_a.mst),
      .send_msg(send_msg), .send_valid(send_valid), .send_ready(send_ready),
      .prbs_en(prbs_en), .prbs_pat(prbs_pat), .inject(inject), .rcv_msg(rcv_msg),
      .rcv_valid(rcv_valid), .rcv_perr(rcv_perr), .bert_locked(bert_locked),
      .bert_errs(bert_errs));
   mlb_dev #(.MBIT(MBIT)) mlb_dev_inst (.sys_clk(sys_clk), .rst(rst), .link(link_a.dev),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tx_msg(tx_msg), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .fwd_msg(fwd_msg), .fwd_valid(fwd_valid));
   mlb_monitor mlb_monitor_inst (.sys_clk(sys_clk), .rst(rst), .link_clk(link_a.link_clk),
      .link_mosi(link_a.link_mosi), .link_miso(link_a.link_miso));

   // wire history: device samples on the rising link edge, master on the falling one
   always @(posedge link_a.link_clk) mosi_hist <= {mosi_hist[14:0], link_a.link_mosi};
   always @(negedge link_a.link_clk) miso_hist <= {miso_hist[14:0], link_a.link_miso};
   always @(posedge sys_clk) if (fwd_valid === 1'b1) n_fwd++;

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] bt(input int n);
      bt = 32'h00000001 << n;
   endfunction
   // tolerant of one trailing idle bit caught after the frame, before the check
   function automatic logic [31:0] frame_ok(input logic [15:0] h, input logic [7:0] m);
      logic [9:0] f;
      f = {1'b1, m, ^m};
      frame_ok = 32'(h[9:0] === f || h[10:1] === f);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge sys_clk);
   endtask
   task automatic ctl(input logic [31:0] v);
      wr(mlb_pkg::CTRL_ADDR, v);
   endtask
   // writes a 0, 1, 0 sequence on one control bit with the counter select beside it
   task automatic pulse(input logic [31:0] b, input logic [1:0] s, input int n);
      logic [31:0] v;
      v = b | (32'(s) << mlb_pkg::SEL_LSB);
      ctl(v);
      ctl(v | bt(n));
      ctl(v);
   endtask
   task automatic cap(input logic [31:0] b, input logic [1:0] s, output logic [31:0] d);
      pulse(b, s, mlb_pkg::CAP_BIT);
      rd(mlb_pkg::STAT_ADDR, d);
      d = d & 32'h00FFFFFF;
   endtask
   task automatic send(input logic [7:0] m);
      send_msg <= m;
      send_valid <= 1'b1;
      @(posedge sys_clk);
      while (send_ready !== 1'b1) @(posedge sys_clk);
      send_valid <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic dsend(input logic [7:0] m);
      tx_msg <= m;
      tx_valid <= 1'b1;
      @(posedge sys_clk);
      while (tx_ready !== 1'b1) @(posedge sys_clk);
      tx_valid <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wait_msg(input logic dev, input logic [7:0] m);
      int i;
      for (i = 0; i < 400 && (dev ? fwd_valid : rcv_valid) !== 1'b1; i++) @(posedge sys_clk);
      if (dev) chk({fwd_valid, fwd_msg}, {1'b1, m});
      else chk({rcv_valid, rcv_perr, rcv_msg}, {2'b10, m});
      @(posedge sys_clk);
   endtask
   task automatic mst_inject;
      inject <= 1'b1;
      @(posedge sys_clk);
      inject <= 1'b0;
      repeat (100) @(posedge sys_clk);
   endtask
   task automatic conclude;
      $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [31:0] base;
      int          i;
      int          p;
      logic [15:0] errs;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(mlb_pkg::CTRL_ADDR, d);
      chk(d, mlb_pkg::CTRL_RESET);
      wr(8'h08, 32'hFFFFFFFF);
      rd(8'h08, d);
      chk(d, 32'h00000000);
      wr(mlb_pkg::STAT_ADDR, 32'h00FFFFFF);
      rd(mlb_pkg::STAT_ADDR, d);
      chk(d, 32'h00000000);
      for (p = 0; p < 4; p++) begin
         ctl(32'(p) << mlb_pkg::PHASE_LSB);
         send(8'hA5 ^ 8'(p));
         wait_msg(1'b1, 8'hA5 ^ 8'(p));
         chk(frame_ok(mosi_hist, 8'hA5 ^ 8'(p)), 32'h00000001);
      end
      dsend(8'h5A);
      wait_msg(1'b0, 8'h5A);
      chk(frame_ok(miso_hist, 8'h5A), 32'h00000001);
      dsend(8'hC3);
      wait_msg(1'b0, 8'hC3);
      // counters in normal mode count messages; clearing hits only the selected one
      cap(0, mlb_pkg::SEL_RX_MSG, d);
      chk(d, 32'h00000004);
      cap(0, mlb_pkg::SEL_RX_ERR, d);
      chk(d, 32'h00000000);
      cap(0, mlb_pkg::SEL_TX_MSG, d);
      chk(d, 32'h00000002);
      pulse(0, mlb_pkg::SEL_RX_MSG, mlb_pkg::CLR_BIT);
      cap(0, mlb_pkg::SEL_RX_MSG, d);
      chk(d, 32'h00000000);
      cap(0, mlb_pkg::SEL_TX_MSG, d);
      chk(d, 32'h00000002);
      pulse(0, mlb_pkg::SEL_TX_MSG, mlb_pkg::CLR_BIT);
      cap(0, mlb_pkg::SEL_TX_MSG, d);
      chk(d, 32'h00000000);
      ctl(bt(mlb_pkg::TXINV_BIT));
      repeat (40) @(posedge sys_clk);
      chk(32'(link_a.link_miso), 32'h00000001);
      ctl(0);
      repeat (200) @(posedge sys_clk);
      // loopback answers locally and forwards nothing
      i = n_fwd;
      ctl(bt(mlb_pkg::LOOP_BIT));
      @(posedge sys_clk);
      chk(32'(tx_ready), 32'h00000000);
      send(mlb_pkg::MSG_START);
      wait_msg(1'b0, mlb_pkg::MSG_START_ACK);
      send(mlb_pkg::MSG_STOP);
      wait_msg(1'b0, mlb_pkg::MSG_BUSY_SET);
      wait_msg(1'b0, mlb_pkg::MSG_BUSY_CLR);
      chk(n_fwd, i);
      ctl(0);
      // tester over every pattern, three injected errors each time: one from the device, two from the master, one of them with compare off
      errs = bert_errs;
      for (p = 0; p < 4; p++) begin
         base = 32'(p) | bt(mlb_pkg::ENA_BIT) | bt(mlb_pkg::RXEN_BIT) | bt(mlb_pkg::TXEN_BIT);
         prbs_pat <= 2'(p);
         pulse(bt(mlb_pkg::ENA_BIT), mlb_pkg::SEL_RX_ERR, mlb_pkg::CLR_BIT);
         pulse(bt(mlb_pkg::ENA_BIT), mlb_pkg::SEL_RX_MSG, mlb_pkg::CLR_BIT);
         pulse(bt(mlb_pkg::ENA_BIT), mlb_pkg::SEL_TX_MSG, mlb_pkg::CLR_BIT);
         // device sends first so no idle bit enters either seed window
         ctl(base & ~bt(mlb_pkg::RXEN_BIT));
         repeat (32) @(posedge sys_clk);
         prbs_en <= 1'b1;
         repeat (320) @(posedge sys_clk);
         ctl(base);
         d = 32'h00000000;
         for (i = 0; i < 800 && !(bert_locked === 1'b1 && d[31] === 1'b1); i++) begin
            rd(mlb_pkg::STAT_ADDR, d);
         end
         chk({bert_locked, d[31]}, 2'b11);
         repeat (400) @(posedge sys_clk);
         chk(bert_errs, errs);
         ctl(base | bt(mlb_pkg::INJ_BIT));
         repeat (400) @(posedge sys_clk);
         chk(bert_errs, errs + 16'h0001);
         errs = errs + 16'h0001;
         cap(base, mlb_pkg::SEL_RX_ERR, d);
         chk(d, 32'h00000000);
         cap(base, mlb_pkg::SEL_RX_MSG, d);
         chk(32'(d != 0), 32'h00000001);
         cap(base, mlb_pkg::SEL_TX_MSG, d);
         chk(32'(d != 0), 32'h00000001);
         ctl(base & ~bt(mlb_pkg::RXEN_BIT));
         mst_inject;
         cap(base & ~bt(mlb_pkg::RXEN_BIT), mlb_pkg::SEL_RX_ERR, d);
         chk(d, 32'h00000000);
         ctl(base);
         mst_inject;
         cap(base, mlb_pkg::SEL_RX_ERR, d);
         chk(d, 32'h00000001);
         prbs_en <= 1'b0;
         repeat (16) @(posedge sys_clk);
         ctl(0);
         repeat (200) @(posedge sys_clk);
      end
      // an inverted idle line reads as broken frames, which are never forwarded
      pulse(0, mlb_pkg::SEL_RX_ERR, mlb_pkg::CLR_BIT);
      i = n_fwd;
      ctl(bt(mlb_pkg::RXINV_BIT));
      repeat (300) @(posedge sys_clk);
      chk(n_fwd, i);
      cap(bt(mlb_pkg::RXINV_BIT), mlb_pkg::SEL_RX_ERR, d);
      chk(32'(d != 0), 32'h00000001);
      conclude;
   end

   initial begin
      #(40000 * 50);
      n_mismatch++;
      conclude;
   end
endmodule
